// file: hw/scl_pkg.sv
// constants shared by the serial configuration loader
package scl_pkg;
  // register image layout
  localparam int unsigned NUM_CFG_REGS          = 54;
  localparam int unsigned NUM_PORTS             = 9;
  localparam logic [5:0]  REG_SIG_FIRST         = 6'h00;
  localparam logic [5:0]  REG_SIG_SECOND        = 6'h01;
  localparam logic [5:0]  REG_GENERAL           = 6'h02;
  localparam logic [5:0]  REG_PRIO_CLASS        = 6'h03;
  localparam int unsigned REG_PORT_CTRL_BASE    = 4;
  localparam int unsigned REG_VLAN_MASK_BASE    = 13;
  localparam int unsigned REG_TAG_VALUE_BASE    = 22;
  localparam int unsigned REG_STATION_ADDR_BASE = 48;
  localparam int unsigned STATION_ADDR_BYTES    = 6;
  localparam logic [5:0]  REG_LAST              = 6'h35;

  // field positions
  localparam int unsigned GEN_VLAN_ENFORCE_BIT  = 0;
  localparam int unsigned GEN_BUF_RESERVE_BIT   = 1;
  localparam int unsigned GEN_PRIO_SCHEME_LSB   = 2;
  localparam int unsigned PORT_QUEUE_SPLIT_BIT  = 0;
  localparam int unsigned PORT_TAG_STRIP_BIT    = 1;
  localparam int unsigned PORT_TAG_INSERT_BIT   = 2;
  localparam int unsigned PORT_PRIO_HIGH_BIT    = 3;
  localparam int unsigned PORT_8021P_EN_BIT     = 4;
  localparam int unsigned PORT_DSCP_EN_BIT      = 5;

  // values after reset
  localparam logic [7:0]  RST_PRIO_CLASS        = 8'hF0;
  localparam logic [7:0]  RST_OTHER             = 8'h00;

  // serial memory addressing
  localparam logic [3:0]  MEM_TYPE_CODE         = 4'hA;
  localparam logic [2:0]  MEM_SUB_ADDR          = 3'h0;
  localparam logic [7:0]  MEM_START_ADDR        = 8'h00;

  // link timing: one quarter of a serial clock period
  localparam int unsigned MCLK_PERIOD_NS        = 10;
  localparam int unsigned LINK_QUARTER_NS       = 2500;
  localparam int unsigned QUARTER_CYCLES        =
    (LINK_QUARTER_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
  localparam logic [8:0]  QUARTER_LAST          = 9'(QUARTER_CYCLES - 1);
  localparam logic [3:0]  ACK_BIT               = 4'h8;

  typedef enum logic [5:0] {
    ST_IDLE  = 6'b000001,
    ST_START = 6'b000010,
    ST_BIT   = 6'b000100,
    ST_STOP  = 6'b001000,
    ST_SLAVE = 6'b010000,
    ST_DONE  = 6'b100000
  } scl_state_type;

  typedef enum logic [1:0] {
    SEQ_SEL_WR = 2'h0,
    SEQ_ADDR   = 2'h1,
    SEQ_SEL_RD = 2'h2,
    SEQ_READ   = 2'h3
  } scl_seq_type;
endpackage : scl_pkg

// file: hw/scl_link_if.sv
// bytes gathered in the link clock domain, handed to the system domain
interface scl_link_if;
  logic [7:0] byte_data;
  logic       byte_tgl;
  logic       link_rst_n;

  modport rx
  (
    output byte_data,
    output byte_tgl,
    input  link_rst_n
  );
  modport ctl
  (
    input  byte_data,
    input  byte_tgl,
    output link_rst_n
  );
endinterface : scl_link_if

// file: hw/scl_slave_rx.sv
// shift receiver on the processor-driven serial clock
module scl_slave_rx
(
  input  wire logic link_clk,
  input  wire logic sda_in,
  scl_link_if.rx    link
);
  logic [6:0] shift_reg;
  logic [2:0] bit_cnt_reg;

  // bit sampled on each rising edge, high order first [RULE8] [RULE11]
  always_ff @(posedge link_clk or negedge link.link_rst_n)
  begin
    if (!link.link_rst_n)
    begin
      shift_reg   <= 7'h00;
      bit_cnt_reg <= 3'h0;
    end
    else
    begin
      shift_reg   <= {shift_reg[5:0], sda_in};
      bit_cnt_reg <= bit_cnt_reg + 3'h1;
    end
  end

  // eighth bit completes a byte; toggle marks it for the other domain
  always_ff @(posedge link_clk or negedge link.link_rst_n)
  begin
    if (!link.link_rst_n)
    begin
      link.byte_data <= 8'h00;
      link.byte_tgl  <= 1'b0;
    end
    else if (bit_cnt_reg == 3'h7)
    begin
      link.byte_data <= {shift_reg, sda_in};
      link.byte_tgl  <= ~link.byte_tgl;
    end
  end
endmodule : scl_slave_rx

// file: hw/scl_cfg_loader.sv
// serial configuration loader: memory master or processor slave
//
// Summary of operation
// RULE1: at start-up read serial memory and store each byte in its register.
// RULE2: first two bytes must equal signature; otherwise ignore all later bytes.
// RULE3: start is data falling while clock high; stop is data rising while high.
// RULE4: data changes only while clock is low, except start and stop.
// RULE5: memory device select uses sub-address bits fixed at zero.
// RULE6: source select low makes the link a slave driven by a processor.
// RULE7: processor keeps the serial clock at or below 8 MHz; the bench processor model runs it at 12.5 MHz (80 ns period).
// RULE8: in slave mode each bit is sampled on the rising clock edge.
// RULE9: processor supplies exactly the bits for all registers.
// RULE10: switch does not start until every register is loaded; in master mode a NACK ends the load early and the switch still starts.
// RULE11: processor bits go high order first, register 0 up to 53.
// RULE12: registers 13-21 hold per-port masks over the other ports ascending.
// RULE13: multicast and broadcast always obey the ingress VLAN mask.
// RULE14: register 2 bit 0 set limits unicast to VLAN; clear lets it cross.
// RULE15: register 4-12 bit 2 set inserts tags on untagged frames.
// RULE16: register 4-12 bit 1 set strips existing tags.
// RULE17: inserted tag value comes from the port's entry in registers 22-39.
// RULE18: registers 48-53 give the source address of control frames.
// RULE19: register 2 bits 3-2 select interleave: all-high, 10:1, 5:1, 2:1.
// RULE20: register 2 bit 1 set reserves 6KB buffer for high priority.
// RULE21: register 3 bit n marks tag priority n high; bits 7-4 default 1.
// RULE22: port control registers 4 through 12 belong to ports 1 through 9.
// RULE23: on signature failure keep defaults and still start the switch.
// RULE24: master reads addresses 0 to 53 in one sequence then stops.
module scl_cfg_loader #(
  // signature values below are arbitrary
  parameter logic [7:0] SIG_FIRST  = 8'hA5,
  parameter logic [7:0] SIG_SECOND = 8'h3C
)
(
  input  wire  logic                   mclk,
  input  wire  logic                   nrst,
  input  wire  logic                   config_source_select,
  input  wire  logic                   link_clk,
  output logic                         cfg_clk_out,
  output logic                         cfg_clk_oe,
  input  wire  logic                   cfg_data_in,
  output logic                         cfg_data_out,
  output logic                         cfg_data_oe,
  input  wire  logic [3:0]             fwd_ingress_port,
  input  wire  logic [8:0]             fwd_dest_mask,
  input  wire  logic                   fwd_unicast,
  input  wire  logic [2:0]             prio_tag,
  output logic                         fwd_allowed_valid,
  output logic       [8:0]             fwd_allowed,
  output logic                         prio_tag_high,
  output logic                         switch_start,
  output logic                         sig_fail,
  output logic                         vlan_enforce,
  output logic                         buf_reserve,
  output logic       [1:0]             prio_scheme,
  output logic       [8:0]             tag_insert,
  output logic       [8:0]             tag_strip,
  output logic       [8:0]             queue_split,
  output logic       [8:0]             port_prio_high,
  output logic       [8:0]             port_8021p_en,
  output logic       [8:0]             port_dscp_en,
  output logic       [8:0][15:0]       tag_value,
  output logic       [47:0]            station_addr
);
  scl_link_if link ();

  logic [7:0]               cfg_reg [0:scl_pkg::NUM_CFG_REGS-1];
  scl_pkg::scl_state_type   state_reg;
  scl_pkg::scl_seq_type     seq_reg;
  logic [8:0]               qcnt_reg;
  logic                     tick_reg;
  logic [1:0]               qph_reg;
  logic [3:0]               bit_reg;
  logic [7:0]               tx_reg;
  logic [7:0]               rx_reg;
  logic [5:0]               rd_cnt_reg;
  logic                     nack_reg;
  logic                     mst_vld_reg;
  logic [7:0]               mst_byte_reg;
  logic [5:0]               load_idx_reg;
  logic                     sig_bad_reg;
  logic                     sel_s1_reg;
  logic                     sel_s2_reg;
  logic                     sda_s1_reg;
  logic                     sda_s2_reg;
  logic                     tgl_s1_reg;
  logic                     tgl_s2_reg;
  logic                     tgl_s3_reg;
  logic                     link_rst_n_reg;
  logic                     slv_vld;
  logic                     byte_vld;
  logic [7:0]               byte_val;
  logic                     reading;

  // ingress-relative mask to physical egress ports, port numbers 1..9
  function automatic logic [8:0] vlan_to_phys(input logic [3:0] ingress,
                                              input logic [7:0] mask);
    logic [8:0] res;
    res = 9'h000;
    for (int p = 1; p <= 9; p++)
    begin
      if (p < int'(ingress))
        res[p-1] = mask[p-1];                                  // [RULE12]
      else if (p > int'(ingress))
        res[p-1] = mask[p-2];                                  // [RULE12]
    end
    return res;
  endfunction : vlan_to_phys

  // link-domain reset held from the system domain
  always_ff @(posedge mclk)
  begin
    link_rst_n_reg <= nrst;
  end
  assign link.link_rst_n = link_rst_n_reg;

  scl_slave_rx u_slave_rx
  (
    .link_clk (link_clk),
    .sda_in   (cfg_data_in),
    .link     (link.rx)
  );

  // pin and cross-domain synchronisers
  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      sel_s1_reg <= 1'b1;
      sel_s2_reg <= 1'b1;
      sda_s1_reg <= 1'b1;
      sda_s2_reg <= 1'b1;
      tgl_s1_reg <= 1'b0;
      tgl_s2_reg <= 1'b0;
      tgl_s3_reg <= 1'b0;
    end
    else
    begin
      sel_s1_reg <= config_source_select;
      sel_s2_reg <= sel_s1_reg;
      sda_s1_reg <= cfg_data_in;
      sda_s2_reg <= sda_s1_reg;
      tgl_s1_reg <= link.byte_tgl;
      tgl_s2_reg <= tgl_s1_reg;
      tgl_s3_reg <= tgl_s2_reg;
    end
  end

  // quarter-period tick for the master link
  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      qcnt_reg <= 9'h000;
      tick_reg <= 1'b0;
    end
    else
    begin
      tick_reg <= (qcnt_reg == scl_pkg::QUARTER_LAST);
      qcnt_reg <= (qcnt_reg == scl_pkg::QUARTER_LAST) ? 9'h000 : qcnt_reg + 9'h001;
    end
  end

  assign reading = (seq_reg == scl_pkg::SEQ_READ);

  // master link engine and mode choice
  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      state_reg    <= scl_pkg::ST_IDLE;
      seq_reg      <= scl_pkg::SEQ_SEL_WR;
      qph_reg      <= 2'h0;
      bit_reg      <= 4'h0;
      tx_reg       <= 8'h00;
      rx_reg       <= 8'h00;
      rd_cnt_reg   <= 6'h00;
      nack_reg     <= 1'b0;
      mst_vld_reg  <= 1'b0;
      mst_byte_reg <= 8'h00;
      cfg_clk_oe   <= 1'b0;
      cfg_data_oe  <= 1'b0;
    end
    else
    begin
      mst_vld_reg <= 1'b0;
      case (state_reg)
        scl_pkg::ST_IDLE:
        begin
          if (tick_reg)
          begin
            if (!sel_s2_reg)
              state_reg <= scl_pkg::ST_SLAVE;                    // [RULE6]
            else
            begin
              state_reg <= scl_pkg::ST_START;
              seq_reg   <= scl_pkg::SEQ_SEL_WR;
              tx_reg    <= {scl_pkg::MEM_TYPE_CODE, scl_pkg::MEM_SUB_ADDR, 1'b0}; // [RULE5]
              qph_reg   <= 2'h0;
            end
          end
        end
        scl_pkg::ST_START:
        begin
          if (tick_reg)
          begin
            qph_reg <= qph_reg + 2'h1;
            case (qph_reg)
              2'h0:    cfg_data_oe <= 1'b0;
              2'h1:    cfg_clk_oe  <= 1'b0;
              2'h2:    cfg_data_oe <= 1'b1;                    // [RULE3]
              default:
              begin
                cfg_clk_oe <= 1'b1;
                bit_reg    <= 4'h0;
                state_reg  <= scl_pkg::ST_BIT;
              end
            endcase
          end
        end
        scl_pkg::ST_BIT:
        begin
          if (tick_reg)
          begin
            qph_reg <= qph_reg + 2'h1;
            case (qph_reg)
              2'h0:
              begin
                // data set only while clock low [RULE4]
                if (bit_reg == scl_pkg::ACK_BIT)
                  cfg_data_oe <= reading && (rd_cnt_reg != scl_pkg::REG_LAST);
                else
                  cfg_data_oe <= !reading && !tx_reg[7];
              end
              2'h1:    cfg_clk_oe <= 1'b0;
              2'h2:
              begin
                if (bit_reg != scl_pkg::ACK_BIT)
                  rx_reg <= {rx_reg[6:0], sda_s2_reg};
                else if (!reading && sda_s2_reg)
                  nack_reg <= 1'b1;
              end
              default:
              begin
                cfg_clk_oe <= 1'b1;
                bit_reg    <= bit_reg + 4'h1;
                tx_reg     <= {tx_reg[6:0], 1'b0};
                if (bit_reg == scl_pkg::ACK_BIT)
                begin
                  bit_reg <= 4'h0;
                  if (nack_reg)
                    state_reg <= scl_pkg::ST_STOP;
                  else
                  begin
                    case (seq_reg)
                      scl_pkg::SEQ_SEL_WR:
                      begin
                        seq_reg <= scl_pkg::SEQ_ADDR;
                        tx_reg  <= scl_pkg::MEM_START_ADDR;      // [RULE24]
                      end
                      scl_pkg::SEQ_ADDR:
                      begin
                        seq_reg   <= scl_pkg::SEQ_SEL_RD;
                        tx_reg    <= {scl_pkg::MEM_TYPE_CODE, scl_pkg::MEM_SUB_ADDR, 1'b1};
                        state_reg <= scl_pkg::ST_START;
                      end
                      scl_pkg::SEQ_SEL_RD: seq_reg <= scl_pkg::SEQ_READ;
                      default:
                      begin
                        mst_vld_reg  <= 1'b1;                  // [RULE1]
                        mst_byte_reg <= rx_reg;
                        rd_cnt_reg   <= rd_cnt_reg + 6'h01;
                        if (rd_cnt_reg == scl_pkg::REG_LAST)
                          state_reg <= scl_pkg::ST_STOP;         // [RULE24]
                      end
                    endcase
                  end
                end
              end
            endcase
          end
        end
        scl_pkg::ST_STOP:
        begin
          if (tick_reg)
          begin
            qph_reg <= qph_reg + 2'h1;
            case (qph_reg)
              2'h0:    cfg_data_oe <= 1'b1;
              2'h1:    cfg_clk_oe  <= 1'b0;
              2'h2:    cfg_data_oe <= 1'b0;                    // [RULE3]
              default: state_reg   <= scl_pkg::ST_DONE;
            endcase
          end
        end
        scl_pkg::ST_SLAVE:
        begin
          if (load_idx_reg > scl_pkg::REG_LAST)
            state_reg <= scl_pkg::ST_DONE;
        end
        scl_pkg::ST_DONE:
        begin
          cfg_clk_oe  <= 1'b0;
          cfg_data_oe <= 1'b0;
        end
        default: state_reg <= scl_pkg::ST_IDLE;
      endcase
    end
  end

  assign slv_vld  = (state_reg == scl_pkg::ST_SLAVE) && (tgl_s2_reg != tgl_s3_reg);
  assign byte_vld = mst_vld_reg || slv_vld;
  assign byte_val = mst_vld_reg ? mst_byte_reg : link.byte_data;

  // byte store with signature check; surplus bytes ignored
  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      load_idx_reg <= 6'h00;
      sig_bad_reg  <= 1'b0;
      for (int i = 0; i < scl_pkg::NUM_CFG_REGS; i++)
        cfg_reg[i] <= (i == int'(scl_pkg::REG_PRIO_CLASS)) ?
                      scl_pkg::RST_PRIO_CLASS : scl_pkg::RST_OTHER;     // [RULE21]
    end
    else if (byte_vld && (load_idx_reg <= scl_pkg::REG_LAST))
    begin
      load_idx_reg <= load_idx_reg + 6'h01;                            // [RULE11]
      if (load_idx_reg == scl_pkg::REG_SIG_FIRST)
      begin
        if (byte_val != SIG_FIRST)
          sig_bad_reg <= 1'b1;                                         // [RULE2]
      end
      else if (load_idx_reg == scl_pkg::REG_SIG_SECOND)
      begin
        if (byte_val != SIG_SECOND)
          sig_bad_reg <= 1'b1;                                         // [RULE2]
      end
      else if (!sig_bad_reg)
        cfg_reg[load_idx_reg] <= byte_val;                             // [RULE1] [RULE23]
    end
  end

  // start held until the load ends, whether or not the signature held
  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      switch_start <= 1'b0;
      sig_fail     <= 1'b0;
      cfg_clk_out  <= 1'b0;
      cfg_data_out <= 1'b0;
    end
    else
    begin
      switch_start <= (state_reg == scl_pkg::ST_DONE);                 // [RULE10] [RULE23]
      sig_fail     <= (state_reg == scl_pkg::ST_DONE) && (sig_bad_reg || nack_reg);
    end
  end

  // forwarding permission and tag priority lookups
  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      fwd_allowed       <= 9'h000;
      fwd_allowed_valid <= 1'b0;
      prio_tag_high     <= 1'b0;
    end
    else
    begin
      fwd_allowed_valid <= switch_start;
      prio_tag_high     <= cfg_reg[scl_pkg::REG_PRIO_CLASS][prio_tag];  // [RULE21]
      if ((fwd_ingress_port == 4'h0) || (fwd_ingress_port > 4'h9))
        fwd_allowed <= 9'h000;
      else if (fwd_unicast && !vlan_enforce)
        fwd_allowed <= fwd_dest_mask &
                       ~(9'h001 << (fwd_ingress_port - 4'h1));           // [RULE14]
      else
        fwd_allowed <= fwd_dest_mask & vlan_to_phys(fwd_ingress_port,
                       cfg_reg[scl_pkg::REG_VLAN_MASK_BASE +
                               32'(fwd_ingress_port) - 1]);           // [RULE13] [RULE14]
    end
  end

  // global settings
  assign vlan_enforce = cfg_reg[scl_pkg::REG_GENERAL][scl_pkg::GEN_VLAN_ENFORCE_BIT]; // [RULE14]
  assign buf_reserve  = cfg_reg[scl_pkg::REG_GENERAL][scl_pkg::GEN_BUF_RESERVE_BIT];  // [RULE20]
  assign prio_scheme  = cfg_reg[scl_pkg::REG_GENERAL][scl_pkg::GEN_PRIO_SCHEME_LSB +: 2]; // [RULE19]

  // per-port settings, port p+1 at base plus p, tag value at base plus 2p
  for (genvar p = 0; p < scl_pkg::NUM_PORTS; p++)
  begin : g_port
    localparam int unsigned CR = scl_pkg::REG_PORT_CTRL_BASE + p;      // [RULE22]
    localparam int unsigned TV = scl_pkg::REG_TAG_VALUE_BASE + 2 * p;
    assign tag_insert[p]     = cfg_reg[CR][scl_pkg::PORT_TAG_INSERT_BIT]; // [RULE15]
    assign tag_strip[p]      = cfg_reg[CR][scl_pkg::PORT_TAG_STRIP_BIT];  // [RULE16]
    assign queue_split[p]    = cfg_reg[CR][scl_pkg::PORT_QUEUE_SPLIT_BIT];
    assign port_prio_high[p] = cfg_reg[CR][scl_pkg::PORT_PRIO_HIGH_BIT];
    assign port_8021p_en[p]  = cfg_reg[CR][scl_pkg::PORT_8021P_EN_BIT];
    assign port_dscp_en[p]   = cfg_reg[CR][scl_pkg::PORT_DSCP_EN_BIT];
    assign tag_value[p]      = {cfg_reg[TV], cfg_reg[TV+1]};             // [RULE17]
  end

  // station address, lowest register is the first byte on the wire
  for (genvar b = 0; b < scl_pkg::STATION_ADDR_BYTES; b++)
  begin : g_station
    assign station_addr[47-8*b -: 8] =
      cfg_reg[scl_pkg::REG_STATION_ADDR_BASE + b];                     // [RULE18]
  end
endmodule : scl_cfg_loader

// file: testbench/scl_cfg_loader_properties.sv
// port-level checks for the serial configuration loader
module scl_cfg_loader_properties
(
  input logic             mclk,
  input logic             nrst,
  input logic             config_source_select,
  input logic             cfg_clk_oe,
  input logic             cfg_data_oe,
  input logic [3:0]       fwd_ingress_port,
  input logic [8:0]       fwd_dest_mask,
  input logic             fwd_unicast,
  input logic [2:0]       prio_tag,
  input logic [8:0]       fwd_allowed,
  input logic             prio_tag_high,
  input logic             switch_start,
  input logic             sig_fail,
  input logic             vlan_enforce,
  input logic [8:0]       tag_insert,
  input logic [8:0][15:0] tag_value,
  input logic [47:0]      station_addr
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  a_start_cond: assert property (
    $rose(cfg_data_oe) && !cfg_clk_oe |-> ##[240:260] cfg_clk_oe)
    else $error("start not followed by clock low");
  a_stop_cond: assert property (
    $fell(cfg_data_oe) && !cfg_clk_oe |-> ##[1:600] switch_start)
    else $error("stop not followed by start-up");
  a_start_held: assert property (switch_start |=> switch_start)
    else $error("start-up dropped");
  a_fail_start: assert property (sig_fail |-> switch_start)
    else $error("failed load without start-up");
  a_fail_defaults: assert property (
    sig_fail |-> station_addr == 48'h0 && tag_insert == 9'h000 && !vlan_enforce)
    else $error("failed load changed settings");
  a_prio_default: assert property (
    sig_fail |=> prio_tag_high == ($past(prio_tag) >= 3'h4))
    else $error("default class wrong");
  a_unicast_cross: assert property (
    switch_start && fwd_unicast && !vlan_enforce && fwd_ingress_port inside {[4'h1:4'h9]}
    |=> fwd_allowed == ($past(fwd_dest_mask) & ~(9'h001 << ($past(fwd_ingress_port) - 4'h1))))
    else $error("unicast crossing wrong");
  a_fwd_subset: assert property (
    switch_start |=> (fwd_allowed & ~$past(fwd_dest_mask)) == 9'h000)
    else $error("forward outside candidates");
  a_cfg_frozen: assert property (
    switch_start |=> $stable(station_addr) && $stable(tag_value) && $stable(tag_insert))
    else $error("settings moved after start-up");
  a_slave_quiet: assert property (
    !config_source_select [*4] |-> !cfg_clk_oe && !cfg_data_oe)
    else $error("slave mode drives link");
  c_good_load: cover property ($rose(switch_start) && !sig_fail);
  c_bad_load: cover property ($rose(switch_start) && sig_fail);
  c_cross: cover property (switch_start && fwd_unicast && !vlan_enforce);
endmodule : scl_cfg_loader_properties

bind scl_cfg_loader scl_cfg_loader_properties scl_cfg_loader_properties_inst
(
  .mclk(mclk), .nrst(nrst), .config_source_select(config_source_select),
  .cfg_clk_oe(cfg_clk_oe), .cfg_data_oe(cfg_data_oe), .fwd_ingress_port(fwd_ingress_port),
  .fwd_dest_mask(fwd_dest_mask), .fwd_unicast(fwd_unicast), .prio_tag(prio_tag),
  .fwd_allowed(fwd_allowed), .prio_tag_high(prio_tag_high), .switch_start(switch_start),
  .sig_fail(sig_fail), .vlan_enforce(vlan_enforce), .tag_insert(tag_insert),
  .tag_value(tag_value), .station_addr(station_addr)
);

// file: testbench/scl_proc_model.sv
// processor feeding the loader over the serial link
module scl_proc_model
(
  output logic link_clk,
  output logic sda
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    link_clk = 1'b0;
    sda      = 1'b1;
  end
  // clock stands low outside frames; slow pauses between bytes
  task automatic send(input logic [7:0] b [0:53], input logic slow);
    for (int k = 0; k < 54; k++)
    begin
      for (int i = 7; i >= 0; i--)
      begin
        sda = b[k][i];
        #20;
        link_clk = 1'b1;
        #40;
        link_clk = 1'b0;
        #20;
      end
      if (slow)
        #300;
    end
    sda = ~sda;
  endtask : send
endmodule : scl_proc_model

// file: testbench/scl_cfg_loader_tb.sv
// self-checking bench for the serial configuration loader
module scl_cfg_loader_tb;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {int k; logic [47:0] v;} scl_note_type;
  logic             mclk, nrst, sel, pdata, lclk, unic, pth, start, fail, ven, brs, fv;
  logic             clk_oe, dat_oe;
  logic [3:0]       ing;
  logic [8:0]       dst, allowed, ins, strp, qsp, pph, p1p, pds;
  logic [2:0]       ptag;
  logic [1:0]       scheme;
  logic [8:0][15:0] tval;
  logic [47:0]      station_addr;
  logic [7:0]       cap;
  logic [7:0]       img [0:53];
  logic [7:0]       ex [0:53];
  integer           seed = 32'hF288, err_count = 0, comparisons = 0, cycles = 0;
  scl_note_type     notes [$];
  scl_note_type     cur;
  string            names [6] = '{"station_addr", "tag_value", "global_bits", "fwd_prio",
                                  "select_byte", "port_prio"};
  wire              scl_w = ~clk_oe; // released lines float high
  wire              sda_w = ~dat_oe;
  wire              din   = sel ? sda_w : pdata;

  scl_cfg_loader #(.SIG_FIRST(8'hA5), .SIG_SECOND(8'h3C)) scl_cfg_loader_inst
  (
    .mclk(mclk), .nrst(nrst), .config_source_select(sel), .link_clk(lclk),
    .cfg_clk_out(), .cfg_clk_oe(clk_oe), .cfg_data_in(din), .cfg_data_out(),
    .cfg_data_oe(dat_oe), .fwd_ingress_port(ing), .fwd_dest_mask(dst), .fwd_unicast(unic),
    .prio_tag(ptag), .fwd_allowed_valid(fv), .fwd_allowed(allowed), .prio_tag_high(pth),
    .switch_start(start), .sig_fail(fail), .vlan_enforce(ven), .buf_reserve(brs),
    .prio_scheme(scheme), .tag_insert(ins), .tag_strip(strp), .queue_split(qsp),
    .port_prio_high(pph), .port_8021p_en(p1p), .port_dscp_en(pds), .tag_value(tval),
    .station_addr(station_addr)
  );
  scl_proc_model scl_proc_model_inst (.link_clk(lclk), .sda(pdata));

  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic check(input logic [47:0] got, input logic [47:0] exp, input string what);
    comparisons++;
    if (got !== exp)
    begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : conclude

  function automatic logic [8:0] bits(int b);
    logic [8:0] r;
    for (int p = 0; p < 9; p++)
      r[p] = ex[4+p][b];
    return r;
  endfunction : bits

  function automatic logic [47:0] seen(int k);
    case (k)
      0: return station_addr;
      1: return 48'({tval[8], tval[0]});
      2: return 48'({fail, scheme, brs, ven, ins, strp, qsp});
      3: return 48'({fv, pth, allowed});
      4: return 48'(cap);
      default: return 48'({pph, p1p, pds});
    endcase
  endfunction : seen

  function automatic logic [8:0] fwd_exp(int i, logic [8:0] d, logic u, logic [7:0] m,
                                         logic en);
    logic [8:0] v;
    int         j;
    v = 9'h000;
    j = 0;
    for (int p = 1; p <= 9; p++)
      if (p != i)
      begin
        v[p-1] = m[j];
        j++;
      end
    if (u && !en)
      v = ~(9'h001 << (i - 1));
    return d & v;
  endfunction : fwd_exp

  always @(negedge mclk)
  begin
    if (start === 1'b1 && notes.size() > 0)
    begin
      cur = notes.pop_front();
      check(seen(cur.k), cur.v, names[cur.k]);
    end
  end

  always @(posedge mclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 40000)
    begin
      err_count++;
      conclude();
    end
  end

  task automatic restart(input logic s);
    @(posedge mclk);
    nrst <= 1'b0;
    sel  <= s;
    repeat (3) @(posedge mclk);
    nrst <= 1'b1;
    repeat (300) @(posedge mclk);
  endtask : restart

  task automatic note_load(input logic bad);
    ex = img;
    if (bad)
    begin
      foreach (ex[i])
        ex[i] = 8'h00;
      ex[3] = 8'hF0;
    end
    notes.push_back('{0, {ex[48], ex[49], ex[50], ex[51], ex[52], ex[53]}});
    notes.push_back('{1, 48'({ex[38], ex[39], ex[22], ex[23]})});
    notes.push_back('{2, 48'({bad, ex[2][3:0], bits(2), bits(1), bits(0)})});
    notes.push_back('{5, 48'({bits(3), bits(4), bits(5)})});
  endtask : note_load

  task automatic fwd_run();
    int i;
    for (int n = 0; n < 16; n++)
    begin
      i = 1 + ($unsigned($random(seed)) % 9);
      @(posedge mclk);
      ing  <= 4'(i);
      dst  <= 9'($random(seed));
      unic <= 1'($random(seed));
      ptag <= 3'($random(seed));
      @(posedge mclk);
      notes.push_back('{3, 48'({1'b1, ex[3][ptag], fwd_exp(i, dst, unic, ex[12+i], ex[2][0])})});
    end
  endtask : fwd_run

  task automatic finish_test(input string t);
    wait (start === 1'b1);
    repeat (8) @(posedge mclk);
    if (t != "master_nack")
      fwd_run();
    repeat (4) @(posedge mclk);
    $display("test %s done", t);
  endtask : finish_test

  initial
  begin
    nrst = 1'b0;
    sel = 1'b0;
    ing = 4'h0;
    dst = 9'h000;
    unic = 1'b0;
    ptag = 3'h0;
    foreach (img[i])
      img[i] = 8'($random(seed));
    img[0] = 8'hA5;
    img[1] = 8'h3C;
    img[2] = {4'h0, img[2][3:1], 1'b1};
    for (int p = 4; p < 13; p++)
      img[p][7:6] = 2'h0;
    restart(1'b0);
    note_load(1'b0);
    scl_proc_model_inst.send(img, 1'b0);
    finish_test("slave_good");
    img[1] = 8'h3D;
    restart(1'b0);
    note_load(1'b1);
    scl_proc_model_inst.send(img, 1'b1);
    finish_test("slave_bad_signature");
    restart(1'b1);
    note_load(1'b1);
    @(negedge sda_w iff scl_w === 1'b1);
    repeat (8)
    begin
      @(posedge scl_w);
      cap = {cap[6:0], sda_w};
    end
    notes.push_back('{4, 48'h0000000000A0});
    finish_test("master_nack");
    conclude();
  end
endmodule : scl_cfg_loader_tb
